// File: clk_fanout_driver.sv
// digital model of a loop clock driver with two output banks
// assumes all pins are asynchronous to core_clk_in; reference far slower than it
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - bank a enable low holds five bank a outputs low, high copies the feedback output
// - bank b enable low holds four bank b outputs low, high copies the feedback output
// - loop supply present and reference under 1 MHz: power down, all clock outputs low
// - strap grounded bypasses loop: delayed reference to feedback and enabled banks
// - loop mode outputs high for half the reference period, rounded down, regardless of reference duty
// - loop mode feedback output runs outside power down, independent of bank enables
// - feedback input aligned to reference edge once locked
// - lock at the end of the stabilisation interval after start or reference change, or sooner after four aligned reference edges
// - lock reached within 1 ms of a stable reference
module clk_fanout_driver
#(
  parameter int unsigned STAB_CYC = clk_fanout_pkg::STAB_CYC
)
(
  input  wire logic                                   core_clk_in,
  input  wire logic                                   arst_n_in,
  input  wire logic                                   ce_in,
  input  wire logic                                   ref_clk_in,
  input  wire logic                                   feedback_in,
  input  wire logic                                   bank_a_enable_in,
  input  wire logic                                   bank_b_enable_in,
  input  wire logic                                   loop_supply_strap_in,
  output logic [clk_fanout_pkg::BANK_A_W-1:0]         bank_a_clock_out,
  output logic [clk_fanout_pkg::BANK_B_W-1:0]         bank_b_clock_out,
  output logic                                        feedback_out,
  output logic                                        locked_out,
  output logic                                        power_down_out
);
  localparam int unsigned PW = clk_fanout_pkg::PER_W;
  localparam int unsigned SW = clk_fanout_pkg::STAB_W;
  localparam logic [SW-1:0] STAB_LAST = SW'(STAB_CYC - 1);

  // ***************************************
  // state
  // ***************************************
  typedef struct packed {
    logic [1:0]                              ref_s;
    logic [1:0]                              fb_s;
    logic [1:0]                              ena_s;
    logic [1:0]                              enb_s;
    logic [1:0]                              strap_s;
    logic                                    fb_prev;
    logic [PW-1:0]                           phase;
    logic                                    gen;
    logic [PW-1:0]                           lead;
    logic [PW-1:0]                           meas;
    logic                                    meas_on;
    logic [PW-1:0]                           hi_run;
    logic [PW-1:0]                           p_last;
    logic [SW-1:0]                           stab;
    logic [2:0]                              align;
    logic                                    locked;
    logic                                    pd;
    logic                                    byp;
    logic [clk_fanout_pkg::BANK_A_W-1:0]     a_out;
    logic [clk_fanout_pkg::BANK_B_W-1:0]     b_out;
    logic                                    fbo;
  } drv_t;

  drv_t s_reg;
  drv_t s_next;

  logic          ref_rise;
  logic [PW-1:0] period;
  logic          slow;

  ref_freq_detector u_det
  (
    .core_clk_in (core_clk_in),
    .arst_n_in   (arst_n_in),
    .ce_in       (ce_in),
    .ref_sync_in (s_reg.ref_s[1]),
    .rise_out    (ref_rise),
    .period_out  (period),
    .slow_out    (slow)
  );

  // circular distance from b forward to a inside one period p
  function automatic logic [PW-1:0] circ_dist(input logic [PW-1:0] a, input logic [PW-1:0] b,
                                              input logic [PW-1:0] p);
    circ_dist = (a >= b) ? (a - b) : PW'(a + p - b);
  endfunction

  // ***************************************
  // next state
  // ***************************************
  logic          fb_rise;
  logic          loop_mode;
  logic          changed;
  logic [PW-1:0] rise_at;
  logic          gen_n;

  always_comb
  begin
    s_next         = s_reg;
    s_next.ref_s   = {s_reg.ref_s[0], ref_clk_in};
    s_next.fb_s    = {s_reg.fb_s[0], feedback_in};
    s_next.ena_s   = {s_reg.ena_s[0], bank_a_enable_in};
    s_next.enb_s   = {s_reg.enb_s[0], bank_b_enable_in};
    s_next.strap_s = {s_reg.strap_s[0], loop_supply_strap_in};
    s_next.fb_prev = s_reg.fb_s[1];
    s_next.byp     = s_reg.ref_s[1];
    fb_rise        = s_reg.fb_s[1] & ~s_reg.fb_prev;
    loop_mode      = s_reg.strap_s[1];
    // zero span: distance wraps modulo the counter width
    changed        = ref_rise && (circ_dist(period, s_reg.p_last, 6'h0_0) > clk_fanout_pkg::PER_TOL)
                     && (circ_dist(s_reg.p_last, period, 6'h0_0) > clk_fanout_pkg::PER_TOL);

    // generated clock: rises lead cycles ahead of the next reference edge
    s_next.phase = ref_rise ? '0 : PW'(s_reg.phase + 6'h0_1);
    rise_at      = (period > s_reg.lead) ? PW'(period - s_reg.lead) : '0;
    gen_n        = (period != '0) && (circ_dist(s_reg.phase, rise_at, period) < (period >> 1));
    s_next.gen   = gen_n;
    s_next.hi_run = s_reg.gen ? PW'(s_reg.hi_run + 6'h0_1) : '0;

    // loop delay from generated rise to returning feedback edge
    if (gen_n && !s_reg.gen)
    begin
      s_next.meas    = '0;
      s_next.meas_on = 1'b1;
    end
    else if (s_reg.meas_on)
    begin
      s_next.meas = PW'(s_reg.meas + 6'h0_1);
    end
    if (fb_rise && s_reg.meas_on && !(gen_n && !s_reg.gen))
    begin
      // reference rise shows with phase one short of a full period
      s_next.lead    = PW'(s_reg.meas + 6'h0_2);
      s_next.meas_on = 1'b0;
    end

    // power down and lock tracking
    s_next.pd = loop_mode && slow;
    if (ref_rise)
    begin
      s_next.p_last = period;
    end
    if (s_reg.pd || !loop_mode || changed)
    begin
      s_next.stab   = '0;
      s_next.align  = '0;
      s_next.locked = 1'b0;
    end
    else
    begin
      if (s_reg.stab != STAB_LAST)
      begin
        s_next.stab = SW'(s_reg.stab + 15'h0_001);
      end
      if (ref_rise)
      begin
        s_next.align = fb_rise ? ((s_reg.align == clk_fanout_pkg::ALIGN_N) ? s_reg.align
                                  : 3'(s_reg.align + 3'h1)) : '0;
      end
      if (s_reg.stab == STAB_LAST || s_reg.align == clk_fanout_pkg::ALIGN_N)
      begin
        s_next.locked = 1'b1;
      end
    end

    // output stage
    if (!loop_mode)
    begin
      s_next.fbo   = s_reg.byp;
      s_next.a_out = {clk_fanout_pkg::BANK_A_W{s_reg.byp & s_reg.ena_s[1]}};
      s_next.b_out = {clk_fanout_pkg::BANK_B_W{s_reg.byp & s_reg.enb_s[1]}};
    end
    else if (s_reg.pd)
    begin
      s_next.fbo   = 1'b0;
      s_next.a_out = '0;
      s_next.b_out = '0;
    end
    else
    begin
      s_next.fbo   = s_reg.gen;
      s_next.a_out = {clk_fanout_pkg::BANK_A_W{s_reg.gen & s_reg.ena_s[1]}};
      s_next.b_out = {clk_fanout_pkg::BANK_B_W{s_reg.gen & s_reg.enb_s[1]}};
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      s_reg <= '0;
    end
    else if (ce_in)
    begin
      s_reg <= s_next;
    end
  end

  assign bank_a_clock_out = s_reg.a_out;
  assign bank_b_clock_out = s_reg.b_out;
  assign feedback_out     = s_reg.fbo;
  assign locked_out       = s_reg.locked;
  assign power_down_out   = s_reg.pd;

  // ***************************************
  // assertions
  // ***************************************
  a_bank_a_off: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    ce_in && !s_reg.ena_s[1] |=> bank_a_clock_out == '0)
    else $error("bank a not low while disabled");
  a_bank_b_off: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    ce_in && !s_reg.enb_s[1] |=> bank_b_clock_out == '0)
    else $error("bank b not low while disabled");
  a_pwr_down_low: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    ce_in && s_reg.pd && s_reg.strap_s[1] |=> !feedback_out && bank_a_clock_out == '0 && bank_b_clock_out == '0)
    else $error("outputs active in power down");
  a_bypass_copy: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    ce_in && !s_reg.strap_s[1] |=> feedback_out == $past(s_reg.ref_s[1], 2))
    else $error("bypass feedback not a delayed reference");
  a_duty_half: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    ce_in && s_reg.locked && s_reg.gen && !s_next.gen && !ref_rise |-> s_reg.hi_run == PW'((period >> 1) - 6'h0_1))
    else $error("generated high time not half period");
  a_fb_free_run: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    ce_in && s_reg.strap_s[1] && !s_reg.pd |=> feedback_out == $past(s_reg.gen))
    else $error("feedback output not following loop clock");
  a_unlock_change: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    ce_in && changed && s_reg.strap_s[1] |=> !locked_out ##1 !locked_out)
    else $error("lock kept across reference change");
  a_lock_bound: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    ce_in && s_reg.stab == STAB_LAST && !s_reg.pd && s_reg.strap_s[1] && !changed |=> locked_out)
    else $error("no lock at end of stabilisation");
  a_pd_exit: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    ce_in && s_reg.pd |=> s_reg.stab == '0 && !locked_out)
    else $error("stabilisation not restarted from power down");
endmodule
`default_nettype wire

// File: clk_fanout_pkg.sv
// constants for the loop clock fan-out driver model
// assumes a 25 MHz core clock that samples all pins
package clk_fanout_pkg;
  localparam int unsigned CORE_PERIOD_NS = 40;
  localparam int unsigned PD_FREQ_KHZ    = 1000;
  localparam int unsigned PD_PERIOD_NS   = 1000000 / PD_FREQ_KHZ;
  // longest reference period still counted as a live clock
  localparam logic [5:0]  PD_LIMIT_CYC   = 6'(PD_PERIOD_NS / CORE_PERIOD_NS);
  localparam int unsigned STAB_TIME_US   = 1;
  localparam int unsigned STAB_TIME_MS   = 1;
  localparam int unsigned STAB_CYC       = (STAB_TIME_MS * 1000000) / CORE_PERIOD_NS;
  localparam int unsigned PER_W          = 6;
  localparam int unsigned STAB_W         = 15;
  localparam logic [PER_W-1:0] PER_SAT   = 6'h3_f;
  localparam logic [PER_W-1:0] PER_TOL   = 6'h0_1;
  localparam logic [2:0]  ALIGN_N        = 3'h4;
  localparam int unsigned BANK_A_W       = 5;
  localparam int unsigned BANK_B_W       = 4;
endpackage

// File: ref_freq_detector.sv
// reference period meter and slow-clock detector
// assumes ref_sync_in is already synchronised to core_clk_in
`timescale 1ns/10ps
`default_nettype none
module ref_freq_detector
(
  input  wire logic                                core_clk_in,
  input  wire logic                                arst_n_in,
  input  wire logic                                ce_in,
  input  wire logic                                ref_sync_in,
  output logic                                     rise_out,
  output logic [clk_fanout_pkg::PER_W-1:0]         period_out,
  output logic                                     slow_out
);
  typedef struct packed {
    logic                              prev;
    logic [clk_fanout_pkg::PER_W-1:0]  cnt;
    logic [clk_fanout_pkg::PER_W-1:0]  period;
    logic                              slow;
  } det_t;

  det_t s_reg;
  det_t s_next;

  assign rise_out   = ref_sync_in & ~s_reg.prev;
  assign period_out = s_reg.period;
  assign slow_out   = s_reg.slow;

  always_comb
  begin
    s_next      = s_reg;
    s_next.prev = ref_sync_in;
    if (s_reg.cnt != clk_fanout_pkg::PER_SAT)
    begin
      s_next.cnt = s_reg.cnt + 6'h0_1;
    end
    // no edge for too long: slow or missing reference
    if (s_reg.cnt > clk_fanout_pkg::PD_LIMIT_CYC)
    begin
      s_next.slow = 1'b1;
    end
    if (rise_out)
    begin
      s_next.cnt    = 6'h0_1;
      s_next.period = s_reg.cnt;
      s_next.slow   = (s_reg.cnt > clk_fanout_pkg::PD_LIMIT_CYC);
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      s_reg <= '{prev: 1'b0, cnt: 6'h0_0, period: 6'h0_0, slow: 1'b1};
    end
    else if (ce_in)
    begin
      s_reg <= s_next;
    end
  end
endmodule
`default_nettype wire

// File: ref_source_model.sv
// clock source and board feedback trace seen from the loop clock driver
// assumes the bench changes the period only at the start of a scenario, with run_in high or low
`timescale 1ns/10ps
`default_nettype none
module ref_source_model
(
  input  wire logic       core_clk_in,
  input  wire logic       run_in,
  input  wire logic [5:0] period_in,
  input  wire logic [5:0] high_in,
  input  wire logic       fb_drive_in,
  output logic            ref_clk_out,
  output logic            fb_wire_out
);
  logic [5:0] phase_reg;

  initial
  begin
    phase_reg = 6'h00;
    ref_clk_out = 1'h0;
  end

  // ****************
  // reference source
  // ****************
  // stopped source rests low
  always @(posedge core_clk_in)
  begin
    if (!run_in || phase_reg >= period_in - 6'h01)
      phase_reg <= 6'h00;
    else
      phase_reg <= phase_reg + 6'h01;
    ref_clk_out <= run_in && (phase_reg < high_in);
  end

  assign fb_wire_out = fb_drive_in;
endmodule
`default_nettype wire

// File: pll_clock_fanout_driver_bench.sv
// self-checking bench for the loop clock fan-out driver
// assumes the design files and ref_source_model are compiled first
`timescale 1ns/10ps
`default_nettype none
module pll_clock_fanout_driver_bench;
  localparam int unsigned STAB_SHORT = 200;
  localparam int          LOCK_MAX   = STAB_SHORT + 100;
  logic       core_clk_in = 1'h0;
  logic       arst_n_in = 1'h0;
  logic       strap = 1'h0;
  logic       en_a = 1'h0;
  logic       en_b = 1'h0;
  logic       run = 1'h0;
  logic [5:0] period = 6'h0a;
  logic [5:0] high = 6'h03;
  logic [3:0] hist = 4'h0;
  wire        ref_clk;
  wire        feedback_in;
  wire  [4:0] bank_a_clock_out;
  wire  [3:0] bank_b_clock_out;
  wire        feedback_out;
  wire        locked_out;
  wire        power_down_out;
  int         num_errors = 0;
  int         compares = 0;
  int         cycles = 0;

  clk_fanout_driver #(.STAB_CYC(STAB_SHORT)) DUT (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
    .ce_in(1'h1), .ref_clk_in(ref_clk), .feedback_in(feedback_in), .bank_a_enable_in(en_a),
    .bank_b_enable_in(en_b), .loop_supply_strap_in(strap), .bank_a_clock_out(bank_a_clock_out),
    .bank_b_clock_out(bank_b_clock_out), .feedback_out(feedback_out), .locked_out(locked_out),
    .power_down_out(power_down_out));

  ref_source_model src (.core_clk_in(core_clk_in), .run_in(run), .period_in(period), .high_in(high),
    .fb_drive_in(feedback_out), .ref_clk_out(ref_clk), .fb_wire_out(feedback_in));

  always #20 core_clk_in = ~core_clk_in;

  // reference history for the bypass delay
  always @(posedge core_clk_in)
  begin
    hist <= {hist[2:0], ref_clk};
    cycles++;
    if (cycles == 6000)
    begin
      num_errors++;
      results();
    end
  end

  // ************
  // shared tasks
  // ************
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic drive(input logic st, ea, eb, go, input logic [5:0] per, hi);
    @(posedge core_clk_in);
    strap <= st;
    en_a <= ea;
    en_b <= eb;
    run <= go;
    period <= per;
    high <= hi;
  endtask

  task automatic wait_lock;
    int n;
    n = 0;
    while (locked_out !== 1'h1 && n < LOCK_MAX)
    begin
      @(posedge core_clk_in);
      #1;
      n++;
    end
    check("locked", 8'(locked_out), 8'h01);
    check("pd_live", 8'(power_down_out), 8'h00);
  endtask

  task automatic watch(input int n, input logic a_on, b_on, output int highs, rises, skew);
    logic pf;
    logic pr;
    logic pi;
    highs = 0;
    rises = 0;
    skew = 0;
    pf = feedback_out;
    pr = ref_clk;
    pi = feedback_in;
    repeat (n)
    begin
      @(posedge core_clk_in);
      #1;
      highs += int'(feedback_out === 1'h1);
      rises += int'(feedback_out === 1'h1 && pf === 1'h0);
      skew += int'((ref_clk && !pr) !== (feedback_in && !pi));
      pf = feedback_out;
      pr = ref_clk;
      pi = feedback_in;
      check("bank_a", 8'(bank_a_clock_out), a_on ? 8'({5{feedback_out}}) : 8'h00);
      check("bank_b", 8'(bank_b_clock_out), b_on ? 8'({4{feedback_out}}) : 8'h00);
    end
  endtask

  // *********
  // scenarios
  // *********
  task automatic bypass_test;
    drive(1'h0, 1'h1, 1'h1, 1'h1, 6'h07, 6'h03);
    for (int k = 0; k < 80; k++)
    begin
      if (k == 40)
        drive(1'h0, 1'h0, 1'h0, 1'h1, 6'h07, 6'h03);
      @(posedge core_clk_in);
      #1;
      if (k % 40 > 8)
      begin
        check("byp_fb", 8'(feedback_out), 8'(hist[3]));
        check("byp_a", 8'(bank_a_clock_out), k < 40 ? 8'({5{hist[3]}}) : 8'h00);
        check("byp_b", 8'(bank_b_clock_out), k < 40 ? 8'({4{hist[3]}}) : 8'h00);
      end
    end
  endtask

  task automatic loop_test;
    int h;
    int r;
    int s;
    drive(1'h1, 1'h0, 1'h1, 1'h1, 6'h0a, 6'h03);
    wait_lock();
    watch(100, 1'h0, 1'h1, h, r, s);
    check("duty", 8'(h), 8'd50);
    check("fb_rises", 8'(r), 8'd10);
    check("align", 8'(s), 8'h00);
  endtask

  task automatic power_down_test;
    int h;
    int r;
    int s;
    drive(1'h1, 1'h1, 1'h1, 1'h0, 6'h0c, 6'h07);
    repeat (60) @(posedge core_clk_in);
    #1;
    check("pd", 8'(power_down_out), 8'h01);
    check("pd_lock", 8'(locked_out), 8'h00);
    watch(20, 1'h0, 1'h0, h, r, s);
    check("pd_fb", 8'(h), 8'h00);
    drive(1'h1, 1'h1, 1'h1, 1'h1, 6'h0c, 6'h07);
    wait_lock();
    watch(96, 1'h1, 1'h1, h, r, s);
    check("duty2", 8'(h), 8'd48);
    check("fb_rises2", 8'(r), 8'd8);
    check("align2", 8'(s), 8'h00);
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    repeat (8) @(posedge core_clk_in);
    arst_n_in <= 1'h1;
    bypass_test();
    loop_test();
    power_down_test();
    results();
  end
endmodule
`default_nettype wire
